/* hltm_pkg.sv */
// package for the hardware limit timer mode block
// assumes a single 100 MHz timer clock and no register bus
package hltm_pkg;
    localparam logic [4:0] MODE_LVL_LOW_RST = 5'h06;
    localparam logic [4:0] MODE_LVL_HIGH_RST = 5'h07;
    localparam logic [4:0] MODE_SW_ONESHOT = 5'h08;
    localparam logic [4:0] MODE_EDGE_OS_RISE = 5'h09;
    localparam logic [4:0] MODE_EDGE_OS_FALL = 5'h0A;
    localparam logic [4:0] MODE_EDGE_OS_BOTH = 5'h0B;
    localparam logic [4:0] MODE_HLOS_RISE = 5'h0C;
    localparam logic [4:0] MODE_HLOS_FALL = 5'h0D;
    localparam logic [4:0] MODE_LROS_LOW = 5'h0E;
    localparam logic [4:0] MODE_LROS_HIGH = 5'h0F;
    localparam logic [4:0] MODE_MONO_RISE = 5'h11;
    localparam logic [4:0] MODE_MONO_FALL = 5'h12;
    localparam logic [4:0] MODE_MONO_BOTH = 5'h13;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [1:0] RESTART_CLOCKS = 2'h2;
    localparam logic [1:0] DELAY_IDLE = 2'h0;
    localparam logic [1:0] DELAY_STEP = 2'h1;
endpackage

/* hltm_sync.sv */
// two flip-flop synchroniser for the external reset input
// assumes i_async may change at any time relative to i_clk
module hltm_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_async,
    output logic o_sync
);
    logic meta;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

/* hltm_timer.sv */
// mode control of an 8-bit period timer with external reset input
// assumes timer clock is I_MCLK; run bit and values come from software
module hltm_timer
    import hltm_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic i_run_set,
    input wire logic i_run_clear,
    input wire logic [4:0] i_mode,
    input wire logic [7:0] i_period_value,
    input wire logic [7:0] i_pulse_width_value,
    input wire logic i_external_reset_input,
    output logic O_RUN,
    output logic [7:0] O_TIMER_COUNT,
    output logic O_PWM,
    output logic O_PERIOD_MATCH
);
    // ******************************************************
    // reset release and input synchronisation
    // ******************************************************
    // reset asserts at once but leaves only on a clock edge
    logic rst_meta;
    logic rst_b;
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b <= rst_meta;
        end
    end

    // idle low after reset; edges seen with run low are ignored anyway
    logic ers;
    logic ers_prev;
    hltm_sync u_sync (
        .i_clk(I_MCLK),
        .i_rst_b(rst_b),
        .i_async(i_external_reset_input),
        .o_sync(ers)
    );
    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            ers_prev <= 1'b0;
        end else begin
            ers_prev <= ers;
        end
    end

    // ******************************************************
    // mode decoding
    // ******************************************************
    typedef enum logic [5:0] {
        CLS_LEVEL = 6'b000001,
        CLS_SWOS = 6'b000010,
        CLS_EDGEOS = 6'b000100,
        CLS_HLOS = 6'b001000,
        CLS_LROS = 6'b010000,
        CLS_MONO = 6'b100000
    } hltm_class_type;

    function automatic logic edge_hit(input logic [4:0] mode,
                                      input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        unique case (mode)
            MODE_EDGE_OS_RISE, MODE_HLOS_RISE, MODE_MONO_RISE:
                edge_hit = rise;
            MODE_EDGE_OS_FALL, MODE_HLOS_FALL, MODE_MONO_FALL:
                edge_hit = fall;
            MODE_EDGE_OS_BOTH, MODE_MONO_BOTH:
                edge_hit = rise | fall;
            MODE_LROS_LOW:
                edge_hit = rise;
            MODE_LROS_HIGH:
                edge_hit = fall;
            default:
                edge_hit = 1'b0;
        endcase
    endfunction

    // one compare shared by the period and width matches
    function automatic logic value_hit(input logic [7:0] count,
                                       input logic [7:0] value);
        value_hit = (count == value);
    endfunction

    // ******************************************************
    // mode class
    // ******************************************************
    // unlisted codes decode as idle: no counting and no run clear
    hltm_class_type cls;
    logic cls_valid;
    always_comb begin
        cls = CLS_LEVEL;
        cls_valid = 1'b1;
        unique case (i_mode)
            MODE_LVL_LOW_RST, MODE_LVL_HIGH_RST: cls = CLS_LEVEL;
            MODE_SW_ONESHOT: cls = CLS_SWOS;
            MODE_EDGE_OS_RISE, MODE_EDGE_OS_FALL, MODE_EDGE_OS_BOTH:
                cls = CLS_EDGEOS;
            MODE_HLOS_RISE, MODE_HLOS_FALL: cls = CLS_HLOS;
            MODE_LROS_LOW, MODE_LROS_HIGH: cls = CLS_LROS;
            MODE_MONO_RISE, MODE_MONO_FALL, MODE_MONO_BOTH:
                cls = CLS_MONO;
            default: cls_valid = 1'b0;
        endcase
    end

    // ******************************************************
    // combinational control
    // ******************************************************
    logic edge_now;
    logic level_rst;
    logic per_match;
    logic wid_match;
    logic next_counting;
    logic hold_rst;
    logic start_evt;
    logic clear_run;
    logic counting;
    logic mono_done;
    logic delay_busy;
    logic [1:0] delay_cnt;
    logic pwm_set;
    logic pwm_clr;
    logic count_step;
    logic count_hold;
    logic hw_clear;

    always_comb begin
        edge_now = edge_hit(i_mode, ers, ers_prev);
        // low-level modes read the inverse; the two ff stages give the delay
        level_rst = (i_mode == MODE_LVL_LOW_RST || i_mode == MODE_LROS_LOW)
            ? ~ers : ers;
    end

    always_comb begin
        // the period match only counts while counting, never at an idle zero; the width match is ungated
        per_match = counting && value_hit(O_TIMER_COUNT, i_period_value);
        wid_match = value_hit(O_TIMER_COUNT, i_pulse_width_value);
    end

    always_comb begin
        hold_rst = 1'b0;
        start_evt = 1'b0;
        clear_run = 1'b0;
        next_counting = counting;
        unique case (cls)
            CLS_LEVEL: begin
                hold_rst = O_RUN && level_rst;
                next_counting = O_RUN && !level_rst;
                start_evt = O_RUN && !level_rst && !counting;
            end
            CLS_SWOS: begin
                next_counting = O_RUN;
                start_evt = O_RUN && !counting && O_TIMER_COUNT == COUNT_ZERO;
                clear_run = per_match;
            end
            CLS_EDGEOS: begin
                start_evt = O_RUN && !counting && edge_now;
                next_counting = O_RUN && (counting || edge_now);
                clear_run = per_match;
            end
            CLS_HLOS: begin
                hold_rst = O_RUN && counting && edge_now;
                start_evt = O_RUN && edge_now;
                next_counting = O_RUN && (counting || edge_now);
                clear_run = per_match;
            end
            CLS_LROS: begin
                hold_rst = O_RUN && level_rst;
                start_evt = O_RUN && !counting && edge_now;
                next_counting = O_RUN && !level_rst && (counting || edge_now);
                clear_run = per_match;
            end
            CLS_MONO: begin
                start_evt = O_RUN && !counting && !mono_done
                    && edge_now;
                next_counting = O_RUN && !mono_done
                    && (counting || edge_now) && !per_match;
            end
        endcase
        if (!cls_valid) begin
            next_counting = 1'b0;
            start_evt = 1'b0;
        end
    end

    // ******************************************************
    // run bit: hardware clear loses to a software set
    // ******************************************************
    // an unlisted mode never clears the run bit by itself
    assign hw_clear = clear_run && cls_valid;

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            O_RUN <= 1'b0;
        end else if (i_run_set) begin
            O_RUN <= 1'b1;
        end else if (i_run_clear || hw_clear) begin
            O_RUN <= 1'b0;
        end
    end

    // ******************************************************
    // restart delay after an edge reset in limit one-shot mode
    // ******************************************************
    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            delay_cnt <= DELAY_IDLE;
        end else if (!O_RUN) begin
            delay_cnt <= DELAY_IDLE;
        end else if (hold_rst && cls == CLS_HLOS) begin
            delay_cnt <= RESTART_CLOCKS;
        end else if (delay_cnt != DELAY_IDLE) begin
            delay_cnt <= delay_cnt - DELAY_STEP;
        end
    end
    assign delay_busy = (delay_cnt != DELAY_IDLE);

    // ******************************************************
    // count step and hold
    // ******************************************************
    // the restart delay only ever follows an edge reset in limit one-shot
    always_comb begin
        count_step = counting && O_RUN && !delay_busy;
        count_hold = cls == CLS_MONO && (per_match || mono_done);
    end

    // ******************************************************
    // counter and its state
    // ******************************************************
    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            counting <= 1'b0;
        end else if (!O_RUN) begin
            counting <= 1'b0;
        end else begin
            counting <= next_counting;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            mono_done <= 1'b0;
        end else if (!O_RUN) begin
            mono_done <= 1'b0;
        end else if (cls == CLS_MONO && per_match) begin
            mono_done <= 1'b1;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            O_TIMER_COUNT <= COUNT_ZERO;
        end else if (!O_RUN && cls != CLS_SWOS) begin
            O_TIMER_COUNT <= COUNT_ZERO;
        end else if (hold_rst) begin
            O_TIMER_COUNT <= COUNT_ZERO;
        end else if (count_hold) begin
            O_TIMER_COUNT <= O_TIMER_COUNT;
        end else if (per_match) begin
            O_TIMER_COUNT <= COUNT_ZERO;
        end else if (count_step) begin
            O_TIMER_COUNT <= O_TIMER_COUNT + COUNT_ONE;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            O_PERIOD_MATCH <= 1'b0;
        end else begin
            O_PERIOD_MATCH <= per_match;
        end
    end

    // ******************************************************
    // pwm drive
    // ******************************************************
    // software one-shot keeps its count while run is low, so the drive
    // simply stays set until the width match is reached again
    always_comb begin
        pwm_set = 1'b0;
        pwm_clr = 1'b0;
        if (start_evt) begin
            pwm_set = 1'b1;
        end else if (cls == CLS_LEVEL && per_match && O_RUN) begin
            // level mode starts a fresh pulse on every wrap
            pwm_set = 1'b1;
        end else if (!O_RUN && cls != CLS_SWOS) begin
            pwm_clr = 1'b1;
        end else if (counting && O_RUN && !hold_rst && wid_match
                     && O_TIMER_COUNT != COUNT_ZERO) begin
            // a held reset wins over the width match
            pwm_clr = 1'b1;
        end
    end

    // ******************************************************
    // pwm register
    // ******************************************************
    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            O_PWM <= 1'b0;
        end else if (pwm_set) begin
            O_PWM <= 1'b1;
        end else if (pwm_clr) begin
            O_PWM <= 1'b0;
        end
    end
endmodule

/* hltm_ers_src.sv */
// model of the external reset source feeding the timer
// assumes the bench sets i_lvl on the falling clock edge
module hltm_ers_src (
    input wire logic i_lvl,
    output logic o_ers
);
    timeunit 1ns;
    timeprecision 1ps;
    // skew keeps transitions off both clock edges, as a real pin would
    assign #3 o_ers = i_lvl;
endmodule

/* hltm_timer_chk.sv */
// checker of the timer mode block, bound to its top module
// assumes it sees the top module ports only
module hltm_timer_chk
    import hltm_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic i_run_set,
    input wire logic i_run_clear,
    input wire logic [4:0] i_mode,
    input wire logic [7:0] i_period_value,
    input wire logic [7:0] i_pulse_width_value,
    input wire logic i_external_reset_input,
    input wire logic O_RUN,
    input wire logic [7:0] O_TIMER_COUNT,
    input wire logic O_PWM,
    input wire logic O_PERIOD_MATCH
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_B);
    logic lvl_rst;
    logic one_shot;
    logic mono;
    assign lvl_rst = (i_mode == MODE_LVL_LOW_RST && !i_external_reset_input)
        || (i_mode == MODE_LVL_HIGH_RST && i_external_reset_input);
    assign one_shot = i_mode inside {[MODE_SW_ONESHOT:MODE_LROS_HIGH]};
    assign mono = i_mode inside {[MODE_MONO_RISE:MODE_MONO_BOTH]};
    a_run_set_next: assert property (
        i_run_set |=> O_RUN)
        else $error("run bit not set");
    a_run_clr_next: assert property (
        i_run_clear && !i_run_set |=> !O_RUN)
        else $error("run bit not cleared");
    // margin of two edges over the synchroniser latency
    a_level_hold: assert property (
        (lvl_rst && O_RUN)[*5] |-> O_TIMER_COUNT == COUNT_ZERO)
        else $error("count not held at reset level");
    a_idle_zero: assert property (
        (!O_RUN)[*3] ##0 i_mode != MODE_SW_ONESHOT
        |-> O_TIMER_COUNT == COUNT_ZERO)
        else $error("count not zero while off");
    a_match_wrap: assert property (
        O_PERIOD_MATCH && !mono |-> O_TIMER_COUNT == COUNT_ZERO)
        else $error("count not zero at match");
    a_match_cause: assert property (
        O_PERIOD_MATCH |-> $past(O_TIMER_COUNT) == $past(i_period_value))
        else $error("match without period count");
    a_oneshot_stop: assert property (
        O_PERIOD_MATCH && one_shot |-> !O_RUN)
        else $error("run bit kept after match");
    a_pwm_width: assert property (
        $fell(O_PWM) && O_RUN && $past(O_RUN)
        |-> $past(O_TIMER_COUNT) == $past(i_pulse_width_value))
        else $error("pwm ended off the width count");
    a_mono_hold: assert property (
        O_RUN && mono && !i_run_clear && O_TIMER_COUNT == i_period_value
        |=> O_TIMER_COUNT == i_period_value)
        else $error("monostable count moved past period");
    c_match: cover property (O_PERIOD_MATCH && one_shot);
    c_lvl_pwm: cover property (lvl_rst && O_RUN && O_PWM);
    c_pwm_up: cover property ($rose(O_PWM));
endmodule
bind hltm_timer hltm_timer_chk u_chk (
    .I_MCLK(I_MCLK),
    .I_RST_B(I_RST_B),
    .i_run_set(i_run_set),
    .i_run_clear(i_run_clear),
    .i_mode(i_mode),
    .i_period_value(i_period_value),
    .i_pulse_width_value(i_pulse_width_value),
    .i_external_reset_input(i_external_reset_input),
    .O_RUN(O_RUN),
    .O_TIMER_COUNT(O_TIMER_COUNT),
    .O_PWM(O_PWM),
    .O_PERIOD_MATCH(O_PERIOD_MATCH)
);

/* hardware_limit_timer_modes_test.sv */
// testbench of the timer mode block
// assumes package, design, source model and checker compiled first
module hardware_limit_timer_modes_test;
    import hltm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic rst_b = 0;
    logic run_set = 0;
    logic run_clear = 0;
    logic [4:0] mode = 5'h00;
    logic [7:0] per = 8'h05;
    logic [7:0] wid = 8'h03;
    logic lvl = 0;
    logic ers, o_run, pwm, pm, p;
    logic [7:0] cnt;
    int error_cnt = 0;
    int cmp_count = 0;
    initial forever #5 clk = ~clk;
    hltm_ers_src u_src (.i_lvl(lvl), .o_ers(ers));
    hltm_timer DUT (.I_MCLK(clk), .I_RST_B(rst_b), .i_run_set(run_set),
        .i_run_clear(run_clear), .i_mode(mode), .i_period_value(per),
        .i_pulse_width_value(wid), .i_external_reset_input(ers),
        .O_RUN(o_run), .O_TIMER_COUNT(cnt), .O_PWM(pwm),
        .O_PERIOD_MATCH(pm));
    // ****************
    // shared tasks
    // ****************
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: count %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic hit_run(input logic set);
        run_set = set;
        run_clear = !set;
        tick(1);
        run_set = 0;
        run_clear = 0;
    endtask
    // mode is changed only with run off, so no half-done cycle carries over
    task automatic prep(input logic [4:0] m, input logic [7:0] pv,
        input logic [7:0] wv, input logic l);
        hit_run(0);
        mode = m;
        per = pv;
        wid = wv;
        lvl = l;
        tick(4);
    endtask
    task automatic wait_match();
        int i;
        p = 0;
        for (i = 0; i < 400 && pm !== 1'b1; i++) begin
            p = p | pwm;
            tick(1);
        end
        if (i == 400) begin
            error_cnt++;
            $display("Error at %0t: no period match", $time);
            close_out();
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_sw();
        prep(MODE_SW_ONESHOT, 8'h05, 8'h03, 0);
        hit_run(1);
        wait_match();
        cmp1(p, 1);
        cmp1(o_run, 0);
        cmp8(cnt, COUNT_ZERO);
        tick(6);
        cmp8(cnt, COUNT_ZERO);
        cmp1(pwm, 0);
        // pause mid-pulse: count and drive are held while run is low
        hit_run(1);
        tick(3);
        hit_run(0);
        tick(5);
        cmp8(cnt, 8'h03);
        cmp1(pwm, 1);
        hit_run(1);
        wait_match();
        cmp1(o_run, 0);
        cmp1(pwm, 0);
        $display("sw one-shot done");
    endtask
    task automatic t_edge();
        logic [4:0] m;
        for (int k = 0; k < 3; k++) begin
            m = MODE_EDGE_OS_RISE + 5'(k);
            prep(m, 8'h05, 8'h03, m == MODE_EDGE_OS_FALL);
            hit_run(1);
            tick(6);
            cmp8(cnt, COUNT_ZERO);
            lvl = !lvl;
            wait_match();
            cmp1(p, 1);
            cmp1(o_run, 0);
            cmp1(pwm, 0);
        end
        $display("edge one-shot done");
    endtask
    task automatic t_level();
        prep(MODE_LVL_HIGH_RST, 8'h05, 8'h03, 0);
        hit_run(1);
        wait_match();
        cmp1(o_run, 1);
        lvl = 1;
        tick(6);
        cmp8(cnt, COUNT_ZERO);
        tick(3);
        cmp8(cnt, COUNT_ZERO);
        lvl = 0;
        wait_match();
        cmp1(p, 1);
        prep(MODE_LVL_LOW_RST, 8'h05, 8'h03, 0);
        hit_run(1);
        tick(6);
        cmp8(cnt, COUNT_ZERO);
        lvl = 1;
        wait_match();
        cmp1(o_run, 1);
        hit_run(0);
        tick(6);
        cmp8(cnt, COUNT_ZERO);
        cmp1(pwm, 0);
        $display("level limit done");
    endtask
    task automatic t_hlos();
        prep(MODE_HLOS_RISE, 8'h20, 8'h10, 0);
        hit_run(1);
        tick(3);
        lvl = 1;
        tick(14);
        lvl = 0;
        tick(3);
        lvl = 1;
        tick(5);
        cmp1(cnt < 8'h06, 1);
        cmp1(pwm, 1);
        wait_match();
        cmp1(o_run, 0);
        lvl = 0;
        tick(2);
        lvl = 1;
        tick(6);
        cmp8(cnt, COUNT_ZERO);
        $display("edge limit one-shot done");
    endtask
    task automatic t_lros();
        prep(MODE_LROS_LOW, 8'h05, 8'h03, 0);
        hit_run(1);
        tick(8);
        cmp8(cnt, COUNT_ZERO);
        lvl = 1;
        wait_match();
        cmp1(p, 1);
        cmp1(o_run, 0);
        cmp1(pwm, 0);
        $display("level reset one-shot done");
    endtask
    task automatic t_mono();
        prep(MODE_MONO_RISE, 8'h05, 8'h03, 0);
        hit_run(1);
        lvl = 1;
        tick(20);
        cmp8(cnt, 8'h05);
        lvl = 0;
        tick(2);
        lvl = 1;
        tick(6);
        cmp8(cnt, 8'h05);
        cmp1(pwm, 0);
        hit_run(0);
        tick(3);
        cmp8(cnt, COUNT_ZERO);
        prep(5'h00, 8'h05, 8'h03, 0);
        hit_run(1);
        lvl = 1;
        tick(10);
        cmp8(cnt, COUNT_ZERO);
        $display("monostable and unlisted done");
    endtask
    initial begin
        tick(5);
        rst_b = 1;
        tick(3);
        t_sw();
        t_edge();
        t_level();
        t_hlos();
        t_lros();
        t_mono();
        close_out();
    end
endmodule
